// ---- src/predrv_consts.vh ----
// timing, state and configuration constants for the gate predriver control logic
`ifndef PREDRV_CONSTS_VH
`define PREDRV_CONSTS_VH

// clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS 5000
// undervoltage filter time, ns
`define UV_FILTER_NS 700
// active turn-off time after undervoltage, ns (8.0 us)
`define UV_ACTIVE_OFF_NS 8000
// desaturation persistence filter, ns (1.0 us)
`define DESAT_FILTER_NS 1000
// least time rounds up, longest time rounds down
`define UV_FILTER_CYC ((`UV_FILTER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define UV_ACTIVE_OFF_CYC ((`UV_ACTIVE_OFF_NS * 1000) / `CLK_PERIOD_PS)
`define DESAT_FILTER_CYC ((`DESAT_FILTER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// default deadtime plus blanking window, cycles
`define DT_BLANK_CYC 16'h0040

// mode states, one-hot
`define ST_SLEEP 5'h01
`define ST_STANDBY 5'h02
`define ST_INIT 5'h04
`define ST_ENABLE 5'h08
`define ST_FAULT 5'h10

// mode configuration field positions
`define MODE_PROT_BIT 0
`define MODE_FULL_ON_MODE_BIT 1
`define MODE_LOCK_BIT 2

// status and mask field positions
`define FLT_PHASE_BIT 0
`define FLT_DESAT_BIT 1
`define FLT_UV_BIT 2
// mask reset value: all enabled
`define MASK_RESET 3'h7

`endif

// ---- src/phase_monitor.v ----
// per-phase check of the phase node against the gate command after deadtime plus blanking
`timescale 1ns/10ps
module phase_monitor #(
	parameter CNT_W = 16
) (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// window length in cycles
	input wire [CNT_W-1:0] window_cyc,
	// commanded gate states and synchronised phase node level
	input wire hs_on,
	input wire ls_on,
	input wire node_high,
	// error levels
	output reg hs_err_q,
	output reg ls_err_q
);

// ----------------------------------------
// window counters
// ----------------------------------------
reg [CNT_W-1:0] hs_cnt_q; // cycles since high side commanded on
reg [CNT_W-1:0] ls_cnt_q; // cycles since low side commanded on

// counters restart whenever the command drops, so each on period gets its own window
always @(posedge core_clk) begin
	if (!rstn) begin
		hs_cnt_q <= {CNT_W{1'b0}};
		ls_cnt_q <= {CNT_W{1'b0}};
		hs_err_q <= 1'b0;
		ls_err_q <= 1'b0;
	end else begin
		if (!hs_on) begin
			hs_cnt_q <= {CNT_W{1'b0}};
		end else if (hs_cnt_q != window_cyc) begin
			hs_cnt_q <= hs_cnt_q + 1'b1;
		end
		if (!ls_on) begin
			ls_cnt_q <= {CNT_W{1'b0}};
		end else if (ls_cnt_q != window_cyc) begin
			ls_cnt_q <= ls_cnt_q + 1'b1;
		end
		// node still low once the window has elapsed
		hs_err_q <= hs_on && (hs_cnt_q == window_cyc) && !node_high;
		// node still high once the window has elapsed
		ls_err_q <= ls_on && (ls_cnt_q == window_cyc) && node_high;
	end
end

endmodule // phase_monitor

// ---- src/gate_predriver_mode_protection.v ----
// mode state machine, fault protection and gate gating of a three-phase predriver
`timescale 1ns/10ps
`include "predrv_consts.vh"

module gate_predriver_mode_protection #(
	parameter NPH = 3,
	parameter CNT_W = 16
) (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// global controls
	input wire enable_a,
	input wire enable_b,
	// gate commands per phase
	input wire [NPH-1:0] high_side_cmd_in,
	input wire [NPH-1:0] low_side_cmd_in,
	// asynchronous comparators
	input wire [NPH-1:0] phase_node_sense,
	input wire [NPH-1:0] desat_sense,
	input wire gate_supply_uv,
	input wire gate_supply_cutoff,
	input wire logic_supply_low,
	input wire cp_below_on,
	input wire cp_above_off,
	// configuration from the serial port decoder
	input wire [CNT_W-1:0] dt_blank_cyc,
	input wire mode_wr,
	input wire [2:0] mode_data,
	input wire mask_wr,
	input wire [2:0] mask_data,
	input wire clear_latch_group_b,
	input wire [2:0] clear_data,
	// gate drive controls: on, active pull-down, weak hold-off
	output reg [NPH-1:0] hs_gate_on,
	output reg [NPH-1:0] hs_gate_off,
	output reg [NPH-1:0] ls_gate_on,
	output reg [NPH-1:0] ls_gate_off,
	output reg hold_off,
	// status
	output reg [4:0] mode_q,
	output reg [2:0] fault_status_q,
	output reg full_on_mode,
	output reg int_out,
	output reg charge_pump_on
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
localparam SW = 3 * NPH + 5;
wire [SW-1:0] async_in;
reg [SW-1:0] sync1_q; // first stage, read only by second stage
reg [SW-1:0] sync2_q;
assign async_in = {phase_node_sense, desat_sense, high_side_cmd_in, gate_supply_uv,
	gate_supply_cutoff, logic_supply_low, cp_below_on, cp_above_off};

// two flops on every pin input before use
always @(posedge core_clk) begin
	if (!rstn) begin
		sync1_q <= {SW{1'b0}};
		sync2_q <= {SW{1'b0}};
	end else begin
		sync1_q <= async_in;
		sync2_q <= sync1_q;
	end
end

wire [NPH-1:0] node_s = sync2_q[SW-1 -: NPH];
wire [NPH-1:0] desat_s = sync2_q[2*NPH+4 -: NPH];
wire [NPH-1:0] hs_cmd_s = sync2_q[NPH+4 -: NPH];
wire uv_s = sync2_q[4];
wire cutoff_s = sync2_q[3];
wire lowlogic_s = sync2_q[2];
wire cp_lo_s = sync2_q[1];
wire cp_hi_s = sync2_q[0];

// low-side and enable pins synchronised separately
reg [NPH+1:0] ls1_q;
reg [NPH+1:0] ls2_q;
always @(posedge core_clk) begin
	if (!rstn) begin
		ls1_q <= {(NPH+2){1'b0}};
		ls2_q <= {(NPH+2){1'b0}};
	end else begin
		ls1_q <= {enable_a, enable_b, low_side_cmd_in};
		ls2_q <= ls1_q;
	end
end
wire [NPH-1:0] ls_cmd_s = ls2_q[NPH-1:0];
wire en_s = ls2_q[NPH+1] & ls2_q[NPH];

// ----------------------------------------
// phase error detection
// ----------------------------------------
wire [NPH-1:0] hs_err;
wire [NPH-1:0] ls_err;
genvar g;
generate
	for (g = 0; g < NPH; g = g + 1) begin : g_ph
		phase_monitor #(.CNT_W(CNT_W)) u_mon (
			.core_clk(core_clk),
			.rstn(rstn),
			.window_cyc(dt_blank_cyc),
			.hs_on(hs_gate_on[g]),
			.ls_on(ls_gate_on[g]),
			.node_high(node_s[g]),
			.hs_err_q(hs_err[g]),
			.ls_err_q(ls_err[g])
		);
	end
endgenerate
wire phase_err = |(hs_err | ls_err);

// ----------------------------------------
// desaturation and undervoltage filters
// ----------------------------------------
// counts are integers in the header; cut to counter width on purpose
localparam integer DESAT_I = `DESAT_FILTER_CYC;
localparam integer UVF_I = `UV_FILTER_CYC;
localparam integer UVOFF_I = `UV_ACTIVE_OFF_CYC;
localparam [CNT_W-1:0] DESAT_N = DESAT_I[CNT_W-1:0];
localparam [CNT_W-1:0] UVF_N = UVF_I[CNT_W-1:0];
localparam [CNT_W-1:0] UVOFF_N = UVOFF_I[CNT_W-1:0];
reg [CNT_W-1:0] desat_cnt_q; // persistence of desaturation (or high-side phase error)
reg [CNT_W-1:0] uvf_cnt_q; // persistence of undervoltage
reg [CNT_W-1:0] uvoff_cnt_q; // active turn-off timer
reg desat_flt_q;
reg uv_flt_q;
wire desat_raw = |(desat_s & hs_gate_on) | (|hs_err); // high-side phase error also counts

// any gap resets the timer so short glitches are ignored
always @(posedge core_clk) begin
	if (!rstn) begin
		desat_cnt_q <= {CNT_W{1'b0}};
		uvf_cnt_q <= {CNT_W{1'b0}};
		uvoff_cnt_q <= {CNT_W{1'b0}};
		desat_flt_q <= 1'b0;
		uv_flt_q <= 1'b0;
	end else begin
		if (!desat_raw) begin
			desat_cnt_q <= {CNT_W{1'b0}};
		end else if (desat_cnt_q != DESAT_N) begin
			desat_cnt_q <= desat_cnt_q + 1'b1;
		end
		desat_flt_q <= desat_raw && (desat_cnt_q == DESAT_N);
		if (!uv_s) begin
			uvf_cnt_q <= {CNT_W{1'b0}};
		end else if (uvf_cnt_q != UVF_N) begin
			uvf_cnt_q <= uvf_cnt_q + 1'b1;
		end
		uv_flt_q <= uv_s && (uvf_cnt_q == UVF_N);
		// active drive-off window starts on the filtered event
		if (uv_flt_q && !uv_s) begin
			uvoff_cnt_q <= {CNT_W{1'b0}};
		end else if (uv_flt_q && uvoff_cnt_q != UVOFF_N) begin
			uvoff_cnt_q <= uvoff_cnt_q + 1'b1;
		end else if (!uv_flt_q) begin
			uvoff_cnt_q <= {CNT_W{1'b0}};
		end
	end
end
wire uv_active_off = uv_flt_q && (uvoff_cnt_q != UVOFF_N);

// ----------------------------------------
// mode configuration, mask and fault latches
// ----------------------------------------
reg [2:0] mode_cfg_q; // protection enable, full-on, lock
reg [2:0] mask_q;
wire [2:0] flt_now = {uv_flt_q, desat_flt_q, phase_err};

// mode configuration locks after a write with the lock bit, mask writes stay open; set beats clear on latches
always @(posedge core_clk) begin
	if (!rstn) begin
		mode_cfg_q <= 3'h0;
		mask_q <= `MASK_RESET;
		fault_status_q <= 3'h0;
	end else begin
		if (mode_wr && !mode_cfg_q[`MODE_LOCK_BIT]) begin
			mode_cfg_q <= mode_data;
		end
		if (mask_wr) begin
			mask_q <= mask_data;
		end
		// clear only what is absent now, so a live fault stays set
		fault_status_q <= flt_now |
			(fault_status_q & ~({3{clear_latch_group_b}} & clear_data));
	end
end

// ----------------------------------------
// mode state machine
// ----------------------------------------
reg [NPH-1:0] ls_prev_q; // previous low-side command
reg [NPH-1:0] hs_prev_q; // previous high-side command
reg ls_toggled_q; // low side toggled during init
reg [NPH-1:0] boot_ok_q; // low-side pulse seen since enable
reg [NPH-1:0] hs_float_q; // high side floats after supply recovery
reg uv_prev_q;
wire prot_fault = uv_flt_q | ((desat_flt_q | phase_err) & mode_cfg_q[`MODE_PROT_BIT]);

// reset low wins over everything and lands in sleep next edge
always @(posedge core_clk) begin
	if (!rstn) begin
		mode_q <= `ST_SLEEP;
		ls_prev_q <= {NPH{1'b0}};
		hs_prev_q <= {NPH{1'b0}};
		ls_toggled_q <= 1'b0;
		boot_ok_q <= {NPH{1'b0}};
		hs_float_q <= {NPH{1'b0}};
		uv_prev_q <= 1'b0;
	end else begin
		ls_prev_q <= ls_cmd_s;
		hs_prev_q <= hs_cmd_s;
		uv_prev_q <= uv_flt_q;
		// supply recovered: high side floats until low side commanded off
		if (uv_prev_q && !uv_flt_q) begin
			hs_float_q <= {NPH{1'b1}};
		end else begin
			hs_float_q <= hs_float_q & ls_cmd_s;
		end
		if (mode_q == `ST_ENABLE) begin
			boot_ok_q <= boot_ok_q | (ls_prev_q & ~ls_cmd_s);
		end else begin
			boot_ok_q <= {NPH{1'b0}};
		end
		case (mode_q)
			`ST_SLEEP: begin
				mode_q <= en_s ? `ST_INIT : `ST_STANDBY;
			end
			`ST_STANDBY: begin
				ls_toggled_q <= 1'b0;
				if (en_s) begin
					mode_q <= `ST_INIT;
				end
			end
			`ST_INIT: begin
				if (!en_s) begin
					mode_q <= `ST_STANDBY;
				end else if (prot_fault) begin
					mode_q <= `ST_FAULT;
				end else if (|(ls_prev_q ^ ls_cmd_s)) begin
					ls_toggled_q <= 1'b1;
				end else if (ls_toggled_q && |(hs_prev_q ^ hs_cmd_s)) begin
					mode_q <= `ST_ENABLE;
				end
			end
			`ST_ENABLE: begin
				if (!en_s) begin
					mode_q <= `ST_STANDBY;
				end else if (prot_fault) begin
					mode_q <= `ST_FAULT;
				end
			end
			`ST_FAULT: begin
				ls_toggled_q <= 1'b0;
				if (!en_s) begin
					mode_q <= `ST_STANDBY;
				end else if (!prot_fault) begin
					mode_q <= `ST_INIT;
				end
			end
			default: begin
				mode_q <= `ST_SLEEP;
			end
		endcase
	end
end

// ----------------------------------------
// gate drive and outputs
// ----------------------------------------
wire hold = lowlogic_s | cutoff_s | (uv_flt_q && !uv_active_off);
wire in_init = (mode_q == `ST_INIT);
wire in_en = (mode_q == `ST_ENABLE);
// hold-off overrides every command, so no gate is driven on beneath the weak pull-down
wire [NPH-1:0] ls_ok = {NPH{(in_init | in_en) & !uv_flt_q & !hold}};
wire [NPH-1:0] hs_ok = {NPH{in_en & !uv_flt_q & !hold}} & boot_ok_q & ~hs_float_q;
// full-on lets both switches of a phase conduct; otherwise low side wins
wire [NPH-1:0] ls_on_d = ls_ok & ls_cmd_s;
wire [NPH-1:0] hs_on_d = hs_ok & hs_cmd_s & (ls_on_d == {NPH{1'b0}} || full_on_mode ?
	{NPH{1'b1}} : ~ls_on_d);

// registered so every output comes from a flop
always @(posedge core_clk) begin
	if (!rstn) begin
		hs_gate_on <= {NPH{1'b0}};
		hs_gate_off <= {NPH{1'b0}};
		ls_gate_on <= {NPH{1'b0}};
		ls_gate_off <= {NPH{1'b0}};
		hold_off <= 1'b1;
		full_on_mode <= 1'b0;
		int_out <= 1'b0;
		charge_pump_on <= 1'b0;
	end else begin
		hs_gate_on <= hs_on_d;
		ls_gate_on <= ls_on_d;
		// active off outside drive; floating high side and hold-off suppress it
		if (uv_active_off) begin
			hs_gate_off <= {NPH{1'b1}};
			ls_gate_off <= {NPH{1'b1}};
		end else if (hold) begin
			hs_gate_off <= {NPH{1'b0}};
			ls_gate_off <= {NPH{1'b0}};
		end else begin
			// fault mode with protection off keeps high side passive (disabled)
			hs_gate_off <= ~hs_on_d & ~hs_float_q & ~{NPH{mode_q == `ST_FAULT &&
				!mode_cfg_q[`MODE_PROT_BIT]}};
			ls_gate_off <= ~ls_on_d;
		end
		hold_off <= hold && !uv_active_off;
		full_on_mode <= mode_cfg_q[`MODE_FULL_ON_MODE_BIT];
		int_out <= |(fault_status_q & mask_q);
		// hysteretic pump control from the two threshold comparators
		if (cp_lo_s) begin
			charge_pump_on <= 1'b1;
		end else if (cp_hi_s) begin
			charge_pump_on <= 1'b0;
		end
	end
end

endmodule // gate_predriver_mode_protection

// ---- sim/predrv_asserts.sv ----
// concurrent checks on the predriver mode and protection block
`timescale 1ns/10ps
`include "predrv_consts.vh"
module predrv_checker #(
	parameter NPH = 3
) (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// pins
	input wire enable_a,
	input wire [NPH-1:0] low_side_cmd_in,
	// gate drive and status
	input wire [NPH-1:0] hs_gate_on,
	input wire [NPH-1:0] ls_gate_on,
	input wire [NPH-1:0] ls_gate_off,
	input wire hold_off,
	input wire [4:0] mode_q,
	input wire [2:0] fault_status_q,
	input wire int_out
);
	// -------------------------------------------
	// properties
	// -------------------------------------------
	default clocking @(posedge core_clk); endclocking
	// reset is the cause here, so it cannot also disable the check
	reset_to_sleep_a: assert property (!rstn |=> mode_q == `ST_SLEEP && hold_off
		&& hs_gate_on == 0 && ls_gate_on == 0 && !int_out)
		else $error("sleep not entered after reset");
	// hold-off legally suppresses the active pull-down, so it is left out here
	standby_off_a: assert property (disable iff (!rstn) mode_q == `ST_STANDBY
		&& $past(mode_q) == `ST_STANDBY && !hold_off
		|-> ls_gate_off == {NPH{1'b1}} && ls_gate_on == 0)
		else $error("standby gates not actively off");
	enable_drop_a: assert property (disable iff (!rstn)
		mode_q == `ST_ENABLE && !enable_a |-> ##[1:3] mode_q != `ST_ENABLE)
		else $error("enable mode kept with enable low");
	int_source_a: assert property (disable iff (!rstn) int_out |->
		$past(fault_status_q) != 0)
		else $error("interrupt without a latched fault");
	init_no_hs_a: assert property (disable iff (!rstn) mode_q == `ST_INIT |->
		hs_gate_on == 0)
		else $error("high side on during init");
	ls_follow_a: assert property (disable iff (!rstn) mode_q == `ST_ENABLE
		&& $past(mode_q, 4) == `ST_ENABLE && low_side_cmd_in == $past(low_side_cmd_in, 4)
		&& !hold_off |-> ls_gate_on == low_side_cmd_in)
		else $error("low side does not follow command");
	// the gate flop was loaded from the mode of the previous cycle
	hs_rise_a: assert property (disable iff (!rstn) $rose(hs_gate_on[0]) |->
		$past(mode_q) == `ST_ENABLE)
		else $error("high side on outside enable");
	hold_off_gates_a: assert property (disable iff (!rstn) hold_off |->
		(hs_gate_on | ls_gate_on) == 0)
		else $error("gate on during hold-off");
endmodule // predrv_checker

bind gate_predriver_mode_protection predrv_checker #(.NPH(NPH)) i_chk (.core_clk(core_clk),
	.rstn(rstn), .enable_a(enable_a), .low_side_cmd_in(low_side_cmd_in),
	.hs_gate_on(hs_gate_on), .ls_gate_on(ls_gate_on), .ls_gate_off(ls_gate_off),
	.hold_off(hold_off), .mode_q(mode_q), .fault_status_q(fault_status_q), .int_out(int_out));

// ---- sim/power_stage_model.sv ----
// power stage model: phase node level seen by the phase comparator
`timescale 1ns/10ps
module power_stage_model #(
	parameter NPH = 3
) (
	// gate drive from the block
	input wire [NPH-1:0] hs_gate_on,
	input wire [NPH-1:0] ls_gate_on,
	// fault injection: selected nodes forced to a level
	input wire [NPH-1:0] stuck_mask,
	input wire stuck_val,
	// comparator output
	output wire [NPH-1:0] phase_node_sense
);
	// an undriven node bleeds to ground; a stuck node models a shorted switch
	assign phase_node_sense = (stuck_mask & {NPH{stuck_val}}) | (~stuck_mask & hs_gate_on & ~ls_gate_on);
endmodule // power_stage_model

// ---- sim/tb.sv ----
// self-checking testbench of the predriver mode and protection block
`timescale 1ns/10ps
`include "predrv_consts.vh"
module tb;
	// -------------------------------------------
	// signals
	// -------------------------------------------
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg enable_a = 1'b0;
	reg enable_b = 1'b0;
	reg [2:0] high_side_cmd_in = 3'h0;
	reg [2:0] low_side_cmd_in = 3'h0;
	reg gate_supply_uv = 1'b0;
	reg cp_below_on = 1'b0;
	reg cp_above_off = 1'b0;
	reg mask_wr = 1'b0;
	reg mode_wr = 1'b0;
	reg clear_latch_group_b = 1'b0;
	reg [2:0] cfg_data = 3'h0; // shared by mask, clear and mode pulses
	reg supply_cut = 1'b0; // drives both hold-off supply monitors
	reg [2:0] stuck_mask = 3'h0;
	reg stuck_val = 1'b0;
	wire [2:0] phase_node_sense;
	wire [2:0] hs_gate_on;
	wire [2:0] hs_gate_off;
	wire [2:0] ls_gate_on;
	wire [2:0] ls_gate_off;
	wire hold_off;
	wire [4:0] mode_q;
	wire [2:0] fault_status_q;
	wire int_out;
	wire charge_pump_on;
	wire full_on_mode;
	integer n_fail = 0;
	integer num_checks = 0;

	// -------------------------------------------
	// design and partner
	// -------------------------------------------
	gate_predriver_mode_protection i_dut (.core_clk(core_clk), .rstn(rstn),
		.enable_a(enable_a), .enable_b(enable_b), .high_side_cmd_in(high_side_cmd_in),
		.low_side_cmd_in(low_side_cmd_in), .phase_node_sense(phase_node_sense),
		.desat_sense(3'h0), .gate_supply_uv(gate_supply_uv), .gate_supply_cutoff(supply_cut),
		.logic_supply_low(supply_cut), .cp_below_on(cp_below_on), .cp_above_off(cp_above_off),
		.dt_blank_cyc(`DT_BLANK_CYC), .mode_wr(mode_wr), .mode_data(cfg_data), .mask_wr(mask_wr),
		.mask_data(cfg_data), .clear_latch_group_b(clear_latch_group_b),
		.clear_data(cfg_data), .hs_gate_on(hs_gate_on), .hs_gate_off(hs_gate_off),
		.ls_gate_on(ls_gate_on), .ls_gate_off(ls_gate_off), .hold_off(hold_off),
		.mode_q(mode_q), .fault_status_q(fault_status_q), .full_on_mode(full_on_mode),
		.int_out(int_out), .charge_pump_on(charge_pump_on));
	power_stage_model i_stage (.hs_gate_on(hs_gate_on), .ls_gate_on(ls_gate_on),
		.stuck_mask(stuck_mask), .stuck_val(stuck_val), .phase_node_sense(phase_node_sense));

	// 200 MHz clock
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	// -------------------------------------------
	// helpers
	// -------------------------------------------
	// wait n edges, then settle to the falling edge for sampling
	task cyc(input integer n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task chk(input string what, input [15:0] exp, input [15:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("BAD %0s exp %h got %h", what, exp, got);
		end
	endtask
	// bounded wait for a mode; running out ends the run
	task wait_mode(input [4:0] m);
		integer k;
		k = 0;
		while (mode_q !== m && k < 20) begin
			cyc(1);
			k = k + 1;
		end
		chk("mode", {11'h0, m}, {11'h0, mode_q});
		if (mode_q !== m) end_of_test;
	endtask
	// one-cycle config pulse: 1 mask, 2 clear, 3 mode
	task cfg(input integer k, input [2:0] d);
		@(posedge core_clk);
		cfg_data <= d;
		mask_wr <= (k == 1);
		clear_latch_group_b <= (k == 2);
		mode_wr <= (k == 3);
		@(posedge core_clk);
		mask_wr <= 1'b0;
		clear_latch_group_b <= 1'b0;
		mode_wr <= 1'b0;
		cyc(3);
	endtask
	task end_of_test;
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// -------------------------------------------
	// scenarios
	// -------------------------------------------
	task t_init;
		@(posedge core_clk) enable_a <= 1'b1;
		enable_b <= 1'b1;
		wait_mode(`ST_INIT);
		@(posedge core_clk) low_side_cmd_in <= 3'h7;
		cyc(4);
		chk("init_ls", 16'h7, {13'h0, ls_gate_on});
		@(posedge core_clk) low_side_cmd_in <= 3'h0;
		cyc(2);
		@(posedge core_clk) high_side_cmd_in <= 3'h7;
		cyc(2);
		@(posedge core_clk) high_side_cmd_in <= 3'h0;
		wait_mode(`ST_ENABLE);
		@(posedge core_clk) high_side_cmd_in <= 3'h1;
		cyc(5);
		chk("hs_wait", 16'h0, {13'h0, hs_gate_on});
		@(posedge core_clk) low_side_cmd_in <= 3'h1;
		cyc(4);
		@(posedge core_clk) low_side_cmd_in <= 3'h0;
		cyc(5);
		chk("hs_follow", 16'h1, {13'h0, hs_gate_on});
		@(posedge core_clk) high_side_cmd_in <= 3'h0;
		cyc(4);
	endtask
	task t_pump;
		@(posedge core_clk) cp_below_on <= 1'b1;
		cyc(4);
		chk("pump_on", 16'h1, {15'h0, charge_pump_on});
		@(posedge core_clk) cp_below_on <= 1'b0;
		cyc(4);
		chk("pump_hyst", 16'h1, {15'h0, charge_pump_on});
		@(posedge core_clk) cp_above_off <= 1'b1;
		cyc(4);
		chk("pump_off", 16'h0, {15'h0, charge_pump_on});
		@(posedge core_clk) cp_above_off <= 1'b0;
	endtask
	// low supply forces hold-off over a live low-side command
	task t_cut;
		@(posedge core_clk) low_side_cmd_in <= 3'h1;
		supply_cut <= 1'b1;
		cyc(4);
		chk("cut_hold", 16'h8, {12'h0, hold_off, ls_gate_on});
		@(posedge core_clk) supply_cut <= 1'b0;
		cyc(4);
		chk("cut_free", 16'h1, {12'h0, hold_off, ls_gate_on});
		@(posedge core_clk) low_side_cmd_in <= 3'h0;
		cyc(4);
	endtask
	// low side of phase 2 on while its node is shorted high
	task t_phase;
		cfg(1, 3'h6);
		@(posedge core_clk) low_side_cmd_in <= 3'h4;
		stuck_mask <= 3'h4;
		stuck_val <= 1'b1;
		cyc(75);
		chk("phase_flag", 16'h1, {15'h0, fault_status_q[0]});
		chk("int_masked", 16'h0, {15'h0, int_out});
		cfg(1, 3'h7);
		chk("int_unmask", 16'h1, {15'h0, int_out});
		cfg(2, 3'h1);
		chk("int_held", 16'h1, {15'h0, int_out});
		@(posedge core_clk) stuck_mask <= 3'h0;
		low_side_cmd_in <= 3'h0;
		cyc(3);
		cfg(2, 3'h1);
		chk("int_clr", 16'h0, {12'h0, fault_status_q, int_out});
	endtask
	task t_uv;
		@(posedge core_clk) gate_supply_uv <= 1'b1;
		cyc(60);
		@(posedge core_clk) gate_supply_uv <= 1'b0;
		cyc(5);
		chk("uv_glitch", 16'h0, {13'h0, fault_status_q});
		@(posedge core_clk) gate_supply_uv <= 1'b1;
		cyc(150);
		chk("uv_flag", 16'h4, {13'h0, fault_status_q});
		chk("uv_mode", {11'h0, `ST_FAULT}, {11'h0, mode_q});
		chk("uv_active", 16'h3F, {9'h0, hold_off, hs_gate_off, ls_gate_off});
		cyc(1700);
		chk("uv_hold", 16'h1, {15'h0, hold_off});
		@(posedge core_clk) gate_supply_uv <= 1'b0;
		low_side_cmd_in <= 3'h2;
		cyc(5);
		chk("uv_ls", 16'h2, {13'h0, ls_gate_on});
		chk("uv_hs", 16'h0, {13'h0, hs_gate_on});
		wait_mode(`ST_INIT);
		@(posedge core_clk) low_side_cmd_in <= 3'h0;
		cfg(2, 3'h4);
	endtask
	// mode write takes effect once, then the lock refuses a second write
	task t_mode;
		cfg(3, 3'h7);
		chk("full_on_mode_set", 16'h1, {15'h0, full_on_mode});
		cfg(3, 3'h0);
		chk("mode_locked", 16'h1, {15'h0, full_on_mode});
	endtask
	// finish the repeated init, then drop an enable and reset in mid-run
	task t_drop;
		@(posedge core_clk) high_side_cmd_in <= 3'h1;
		wait_mode(`ST_ENABLE);
		@(posedge core_clk) high_side_cmd_in <= 3'h0;
		cyc(2);
		chk("reinit_hs", 16'h0, {13'h0, hs_gate_on});
		@(posedge core_clk) enable_a <= 1'b0;
		wait_mode(`ST_STANDBY);
		cyc(2);
		chk("standby_off", 16'h7, {13'h0, ls_gate_off});
		@(posedge core_clk) rstn <= 1'b0;
		cyc(1);
		chk("sleep", {11'h0, `ST_SLEEP}, {11'h0, mode_q});
		chk("sleep_out", 16'h0, {14'h0, full_on_mode, int_out});
		@(posedge core_clk) rstn <= 1'b1;
		cyc(3);
	endtask

	// -------------------------------------------
	// main sequence
	// -------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		wait_mode(`ST_STANDBY);
		t_init;
		t_pump;
		t_cut;
		t_phase;
		t_uv;
		t_mode;
		t_drop;
		end_of_test;
	end
endmodule // tb
